// *** hdl/dtsc_params.svh ***
// Named constants for the dual-tone signalling codec.
`ifndef DTSC_PARAMS_SVH
`define DTSC_PARAMS_SVH

`define DTSC_CLK_HZ 100000000
`define DTSC_SAMPLE_HZ 8000
`define DTSC_PHASE_ONE 65536
`define DTSC_INC(f) ((((f) * `DTSC_PHASE_ONE) / `DTSC_SAMPLE_HZ))

`define DTSC_ADDR_TXSEL 8'hB6
`define DTSC_ADDR_MODE 8'hC1
`define DTSC_ADDR_ANALOG 8'hC3
`define DTSC_ADDR_IRQ 8'hC6
`define DTSC_ADDR_AUX 8'hCC

`define DTSC_MODE_DTMF_BIT 9
`define DTSC_IRQ_TONE_BIT 3
`define DTSC_LEVEL_MSB 4
`define DTSC_AUX_TAG 3'h2
`define DTSC_NULL_CODE 5'h10

`define DTSC_MODE_RST 16'h0000
`define DTSC_ANALOG_RST 16'h0000
`define DTSC_TXSEL_RST 8'h00
`define DTSC_AUX_RST 5'h10
`define DTSC_IRQ_RST 16'h0000
`define DTSC_RDATA_RST 16'h0000
`define DTSC_PHASE_RST 16'h0000

`define DTSC_TWIST_0DB 6'h20
`define DTSC_TWIST_M2DB 6'h19
`define DTSC_TWIST_M4DB 6'h14
`define DTSC_TWIST_M6DB 6'h10

`define DTSC_SINGLE_HIGH_MASK 16'hFF00
`define DTSC_TRI_MID 16'h4000

`define DTSC_F_L1 697
`define DTSC_F_L2 770
`define DTSC_F_L3 852
`define DTSC_F_L4 941
`define DTSC_F_H1 1209
`define DTSC_F_H2 1336
`define DTSC_F_H3 1477
`define DTSC_F_HC 1447
`define DTSC_F_HA 1663
`define DTSC_F_HD 1633

`endif

// *** hdl/dtsc_pkg.sv ***
// Types shared by the dual-tone signalling codec files.
package dtsc_pkg;
    typedef logic [15:0] dtsc_word_t;
    typedef logic [7:0] dtsc_addr_t;
    typedef logic [4:0] dtsc_code_t;
    typedef struct packed {
        logic mute;
        logic [1:0] twist;
        logic single;
        logic [3:0] digit;
    } dtsc_txsel_s;
endpackage

// *** hdl/dtsc_tone_if.sv ***
// Control and sample signals between the codec core and its tone generator.
`timescale 1ns/100ps
interface dtsc_tone_if;
    logic [15:0] inc_lo;
    logic [15:0] inc_hi;
    logic use_lo;
    logic use_hi;
    logic [5:0] twist_gain;
    logic [4:0] level;
    logic tick;
    logic [15:0] sample;

    modport ctl (
        output inc_lo,
        output inc_hi,
        output use_lo,
        output use_hi,
        output twist_gain,
        output level,
        output tick,
        input sample
    );

    modport gen (
        input inc_lo,
        input inc_hi,
        input use_lo,
        input use_hi,
        input twist_gain,
        input level,
        input tick,
        output sample
    );
endinterface

// *** hdl/dtsc_tone_gen.sv ***
// Two phase-accumulator tone generator with twist and level scaling.
`timescale 1ns/100ps
`include "dtsc_params.svh"
module dtsc_tone_gen (
    input wire logic clk,
    input wire logic rst,
    dtsc_tone_if.gen tone
);
    import dtsc_pkg::*;

    logic [15:0] phase_lo_q;
    logic [15:0] phase_hi_q;
    logic [15:0] sample_q;
    logic signed [15:0] tri_lo;
    logic signed [15:0] tri_hi;
    logic signed [22:0] lo_prod;
    logic signed [15:0] lo_scaled;
    logic signed [16:0] mix;
    logic signed [22:0] lvl_prod;
    logic [15:0] sample_d;

    // A triangle stands in for a sine to avoid a lookup table; harmonics are left to
    // the analogue reconstruction filter.
    function automatic logic signed [15:0] tri_wave(input logic [15:0] p);
        logic [14:0] t;
        t = p[15] ? ~p[14:0] : p[14:0];
        tri_wave = $signed({1'b0, t}) - $signed(`DTSC_TRI_MID);
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_lo_q <= `DTSC_PHASE_RST;
        end else if (tone.tick) begin
            phase_lo_q <= phase_lo_q + tone.inc_lo;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_hi_q <= `DTSC_PHASE_RST;
        end else if (tone.tick) begin
            phase_hi_q <= phase_hi_q + tone.inc_hi;
        end
    end

    always_comb begin
        tri_lo = tone.use_lo ? tri_wave(phase_lo_q) : 16'sh0000;
        tri_hi = tone.use_hi ? tri_wave(phase_hi_q) : 16'sh0000;
        lo_prod = tri_lo * $signed({1'b0, tone.twist_gain});
        lo_scaled = lo_prod[20:5];
        mix = {lo_scaled[15], lo_scaled} + {tri_hi[15], tri_hi};
        lvl_prod = mix * $signed({1'b0, tone.level});
        sample_d = lvl_prod[20:5];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_q <= `DTSC_PHASE_RST;
        end else begin
            sample_q <= sample_d;
        end
    end

    assign tone.sample = sample_q;

    chk_phase_step: assert property (@(posedge clk) disable iff (rst)
        tone.tick |=> phase_lo_q == 16'($past(phase_lo_q) + $past(tone.inc_lo)))
        else $error("low tone phase did not advance by its increment");

    chk_silent_unused: assert property (@(posedge clk) disable iff (rst)
        (!tone.use_lo && !tone.use_hi) [*2] |-> sample_q == 16'h0000)
        else $error("tone output not silent with both tones off");
endmodule

// *** hdl/dtsc_top.sv ***
// Dual-tone signalling encoder and decoder with its control registers.
`timescale 1ns/100ps
`include "dtsc_params.svh"
module dtsc_top #(
    parameter int SAMPLE_DIV = `DTSC_CLK_HZ / `DTSC_SAMPLE_HZ
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire dtsc_pkg::dtsc_addr_t REG_ADDR,
    input wire dtsc_pkg::dtsc_word_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output dtsc_pkg::dtsc_word_t REG_RDATA,
    input wire logic DET_STROBE,
    input wire logic DET_VALID,
    input wire logic [3:0] DET_KEY,
    input wire dtsc_pkg::dtsc_word_t VOICE_IN,
    output dtsc_pkg::dtsc_word_t VOICE_OUT,
    output dtsc_pkg::dtsc_word_t TONE_OUT,
    output logic SAMPLE_TICK
);
    import dtsc_pkg::*;

    localparam int TICK_W = $clog2(SAMPLE_DIV);
    localparam logic [15:0] SINGLE_HIGH = `DTSC_SINGLE_HIGH_MASK;

    dtsc_word_t mode_q;
    dtsc_word_t analog_q;
    dtsc_txsel_s txsel_q;
    dtsc_code_t aux_code_q;
    dtsc_word_t irq_q;
    dtsc_word_t rdata_q;
    dtsc_word_t voice_q;
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick;
    logic dtmf_on;
    logic wr_txsel;
    logic wr_mode;
    logic wr_analog;
    logic rd_irq;
    logic rd_aux;
    logic det_take;
    logic single_high;
    logic [5:0] twist_gain;

    dtsc_tone_if tone_bus();

    // Low-group increment for each digit code.
    function automatic logic [15:0] low_inc(input logic [3:0] d);
        case (d)
            4'h1, 4'h2, 4'h3, 4'hD: low_inc = 16'(`DTSC_INC(`DTSC_F_L1));
            4'h4, 4'h5, 4'h6, 4'hE: low_inc = 16'(`DTSC_INC(`DTSC_F_L2));
            4'h7, 4'h8, 4'h9, 4'hF: low_inc = 16'(`DTSC_INC(`DTSC_F_L3));
            default: low_inc = 16'(`DTSC_INC(`DTSC_F_L4));
        endcase
    endfunction

    // High-group increment for each digit code.
    function automatic logic [15:0] high_inc(input logic [3:0] d);
        case (d)
            4'h1, 4'h4, 4'h7, 4'hB: high_inc = 16'(`DTSC_INC(`DTSC_F_H1));
            4'h2, 4'h5, 4'h8, 4'hA: high_inc = 16'(`DTSC_INC(`DTSC_F_H2));
            4'h3, 4'h6, 4'h9: high_inc = 16'(`DTSC_INC(`DTSC_F_H3));
            4'hC: high_inc = 16'(`DTSC_INC(`DTSC_F_HC));
            4'hD, 4'hE, 4'hF: high_inc = 16'(`DTSC_INC(`DTSC_F_HA));
            default: high_inc = 16'(`DTSC_INC(`DTSC_F_HD));
        endcase
    endfunction

    // Twist is applied to the low-group tone so the high group keeps full level.
    function automatic logic [5:0] twist_to_gain(input logic [1:0] t);
        case (t)
            2'h0: twist_to_gain = `DTSC_TWIST_0DB;
            2'h1: twist_to_gain = `DTSC_TWIST_M2DB;
            2'h2: twist_to_gain = `DTSC_TWIST_M4DB;
            default: twist_to_gain = `DTSC_TWIST_M6DB;
        endcase
    endfunction

    assign wr_txsel = REG_WR && (REG_ADDR == `DTSC_ADDR_TXSEL);
    assign wr_mode = REG_WR && (REG_ADDR == `DTSC_ADDR_MODE);
    assign wr_analog = REG_WR && (REG_ADDR == `DTSC_ADDR_ANALOG);
    assign rd_irq = REG_RD && (REG_ADDR == `DTSC_ADDR_IRQ);
    assign rd_aux = REG_RD && (REG_ADDR == `DTSC_ADDR_AUX);
    assign dtmf_on = mode_q[`DTSC_MODE_DTMF_BIT];
    assign det_take = DET_STROBE && dtmf_on;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mode_q <= `DTSC_MODE_RST;
        end else if (wr_mode) begin
            mode_q <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            analog_q <= `DTSC_ANALOG_RST;
        end else if (wr_analog) begin
            analog_q <= REG_WDATA;
        end
    end

    // The loaded digit and options stay in force until the host writes again.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            txsel_q <= `DTSC_TXSEL_RST;
        end else if (wr_txsel) begin
            txsel_q <= REG_WDATA[7:0];
        end
    end

    // Only the latest detection is kept; software that reads late loses older digits.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            aux_code_q <= `DTSC_AUX_RST;
        end else if (det_take) begin
            aux_code_q <= DET_VALID ? {1'b0, DET_KEY} : `DTSC_NULL_CODE;
        end
    end

    // Reading the status register clears it, but a digit in the same cycle still lands.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            irq_q <= `DTSC_IRQ_RST;
        end else begin
            if (rd_irq) begin
                irq_q <= `DTSC_IRQ_RST;
            end
            if (det_take && DET_VALID) begin
                irq_q[`DTSC_IRQ_TONE_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_q <= `DTSC_RDATA_RST;
        end else if (rd_aux) begin
            rdata_q <= {`DTSC_AUX_TAG, aux_code_q, 8'h00};
        end else if (rd_irq) begin
            rdata_q <= irq_q;
        end else if (REG_RD) begin
            rdata_q <= `DTSC_RDATA_RST;
        end
    end

    // Voice is registered unconditionally so detection can never stall it.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            voice_q <= `DTSC_RDATA_RST;
        end else begin
            voice_q <= VOICE_IN;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    assign tick = (tick_cnt_q == TICK_W'(SAMPLE_DIV - 1));

    assign single_high = SINGLE_HIGH[txsel_q.digit];
    assign twist_gain = twist_to_gain(txsel_q.twist);

    assign tone_bus.inc_lo = low_inc(txsel_q.digit);
    assign tone_bus.inc_hi = high_inc(txsel_q.digit);
    assign tone_bus.use_lo = dtmf_on && !txsel_q.mute
        && !(txsel_q.single && single_high);
    assign tone_bus.use_hi = dtmf_on && !txsel_q.mute
        && !(txsel_q.single && !single_high);
    assign tone_bus.twist_gain = twist_gain;
    assign tone_bus.level = analog_q[`DTSC_LEVEL_MSB:0];
    assign tone_bus.tick = tick;

    dtsc_tone_gen u_gen (
        .clk(CLK),
        .rst(RESET),
        .tone(tone_bus)
    );

    assign REG_RDATA = rdata_q;
    assign VOICE_OUT = voice_q;
    assign TONE_OUT = tone_bus.sample;
    assign SAMPLE_TICK = tick;

    chk_irq_on_digit: assert property (@(posedge CLK) disable iff (RESET)
        det_take && DET_VALID |=> irq_q[`DTSC_IRQ_TONE_BIT])
        else $error("valid digit did not raise the tone status bit");

    chk_code_replace: assert property (@(posedge CLK) disable iff (RESET)
        det_take && DET_VALID |=> aux_code_q == {1'b0, $past(DET_KEY)})
        else $error("detected code did not replace the held code");

    chk_aux_tag: assert property (@(posedge CLK) disable iff (RESET)
        rd_aux |=> REG_RDATA[15:13] == `DTSC_AUX_TAG && REG_RDATA[12:8] == $past(aux_code_q))
        else $error("auxiliary status read lacks tag or code");

    chk_null_code: assert property (@(posedge CLK) disable iff (RESET)
        det_take && !DET_VALID
        |=> aux_code_q == `DTSC_NULL_CODE && !$rose(irq_q[`DTSC_IRQ_TONE_BIT]))
        else $error("absent tone not reported as null code");

    chk_mode_gate: assert property (@(posedge CLK) disable iff (RESET)
        DET_STROBE && !dtmf_on |=> $stable(aux_code_q))
        else $error("detection ran with the signalling mode off");

    chk_voice_pass: assert property (@(posedge CLK) disable iff (RESET)
        ##1 VOICE_OUT == $past(VOICE_IN))
        else $error("voice path delayed or blocked");

    chk_txsel_hold: assert property (@(posedge CLK) disable iff (RESET)
        !wr_txsel |=> $stable(txsel_q))
        else $error("transmit selection changed without a write");

    chk_mute_silent: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.mute [*2] |-> TONE_OUT == 16'h0000)
        else $error("muted generator still produces output");

    chk_level_zero: assert property (@(posedge CLK) disable iff (RESET)
        (analog_q[`DTSC_LEVEL_MSB:0] == 5'h00) [*2] |-> TONE_OUT == 16'h0000)
        else $error("zero level still produces output");

    chk_single_tone: assert property (@(posedge CLK) disable iff (RESET)
        dtmf_on && txsel_q.single && !txsel_q.mute
        |-> tone_bus.use_lo != tone_bus.use_hi)
        else $error("single tone mode drives both or neither tone");

    chk_digit_map: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.digit == 4'h1 |-> tone_bus.inc_lo == 16'(`DTSC_INC(`DTSC_F_L1))
        && tone_bus.inc_hi == 16'(`DTSC_INC(`DTSC_F_H1)))
        else $error("digit one not mapped to its tone pair");

    chk_twist_gain: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.twist == 2'h3 |-> tone_bus.twist_gain == `DTSC_TWIST_M6DB)
        else $error("twist setting gives the wrong gain");

    chk_key_d_map: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.digit == 4'h0 |-> tone_bus.inc_lo == 16'(`DTSC_INC(`DTSC_F_L4))
        && tone_bus.inc_hi == 16'(`DTSC_INC(`DTSC_F_HD)))
        else $error("code zero not mapped to its tone pair");

    chk_key_hash_map: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.digit == 4'hC |-> tone_bus.inc_lo == 16'(`DTSC_INC(`DTSC_F_L4))
        && tone_bus.inc_hi == 16'(`DTSC_INC(`DTSC_F_HC)))
        else $error("hash code not mapped to its tone pair");

    chk_key_c_map: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.digit == 4'hF |-> tone_bus.inc_lo == 16'(`DTSC_INC(`DTSC_F_L3))
        && tone_bus.inc_hi == 16'(`DTSC_INC(`DTSC_F_HA)))
        else $error("last code not mapped to its tone pair");

    chk_key_six_map: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.digit == 4'h6 |-> tone_bus.inc_lo == 16'(`DTSC_INC(`DTSC_F_L2))
        && tone_bus.inc_hi == 16'(`DTSC_INC(`DTSC_F_H3)))
        else $error("digit six not mapped to its tone pair");

    chk_single_high: assert property (@(posedge CLK) disable iff (RESET)
        dtmf_on && txsel_q.single && !txsel_q.mute && txsel_q.digit[3]
        |-> tone_bus.use_hi && !tone_bus.use_lo)
        else $error("upper codes in single tone mode must keep only the high tone");

    chk_single_low: assert property (@(posedge CLK) disable iff (RESET)
        dtmf_on && txsel_q.single && !txsel_q.mute && !txsel_q.digit[3]
        |-> tone_bus.use_lo && !tone_bus.use_hi)
        else $error("lower codes in single tone mode must keep only the low tone");

    chk_twist_flat: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.twist == 2'h0 |-> tone_bus.twist_gain == `DTSC_TWIST_0DB)
        else $error("flat twist setting gives the wrong gain");

    chk_twist_two: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.twist == 2'h1 |-> tone_bus.twist_gain == `DTSC_TWIST_M2DB)
        else $error("two decibel twist setting gives the wrong gain");

    chk_twist_four: assert property (@(posedge CLK) disable iff (RESET)
        txsel_q.twist == 2'h2 |-> tone_bus.twist_gain == `DTSC_TWIST_M4DB)
        else $error("four decibel twist setting gives the wrong gain");

    chk_irq_clear: assert property (@(posedge CLK) disable iff (RESET)
        rd_irq && !(det_take && DET_VALID) |=> irq_q == `DTSC_IRQ_RST)
        else $error("status read did not clear the status register");

    chk_rdata_hold: assert property (@(posedge CLK) disable iff (RESET)
        !REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");

    chk_mode_silent: assert property (@(posedge CLK) disable iff (RESET)
        !dtmf_on [*2] |-> TONE_OUT == 16'h0000)
        else $error("tone output present with the signalling mode off");

    cov_digit_irq: cover property (@(posedge CLK) disable iff (RESET)
        det_take && DET_VALID ##1 rd_irq);
    cov_null_code: cover property (@(posedge CLK) disable iff (RESET)
        det_take && !DET_VALID);
    cov_tone_on: cover property (@(posedge CLK) disable iff (RESET)
        tone_bus.use_lo && tone_bus.use_hi && tick);
    cov_set_clear: cover property (@(posedge CLK) disable iff (RESET)
        rd_irq && det_take && DET_VALID);
endmodule

// *** dv/dtsc_host_model.sv ***
// Host controller model that drives the codec's register strobes.
`timescale 1ns/100ps
`include "dtsc_params.svh"
module dtsc_host_model (
    input wire logic clk,
    output dtsc_pkg::dtsc_addr_t addr,
    output dtsc_pkg::dtsc_word_t wdata,
    output logic wr,
    output logic rd,
    input wire dtsc_pkg::dtsc_word_t rdata
);
    import dtsc_pkg::*;

    initial begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Strobes change at the falling edge, so the rising edge sees them settled.
    task automatic write_reg(input dtsc_addr_t a, input dtsc_word_t d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic read_reg(input dtsc_addr_t a, output dtsc_word_t d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask

    // Only the dual-tone scheme bit is ever set, so no two schemes run together.
    task automatic select_tone_mode(input logic on);
        write_reg(`DTSC_ADDR_MODE, on ? 16'h0200 : 16'h0000);
    endtask

    task automatic send_digit(input logic mute, input logic [1:0] twist, input logic single,
            input logic [3:0] digit);
        write_reg(`DTSC_ADDR_TXSEL, {8'h00, mute, twist, single, digit});
    endtask
endmodule

// *** dv/dtsc_tb.sv ***
// Self-checking bench for the dual-tone signalling codec.
`timescale 1ns/100ps
`include "dtsc_params.svh"
module tb;
    import dtsc_pkg::*;
    logic clk;
    logic reset;
    dtsc_addr_t reg_addr;
    dtsc_word_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    dtsc_word_t reg_rdata;
    logic det_strobe;
    logic det_valid;
    logic [3:0] det_key;
    dtsc_word_t voice_in;
    dtsc_word_t voice_out;
    dtsc_word_t tone_out;
    int failures;
    int cmp_count;
    dtsc_word_t rv;
    dtsc_word_t pk;
    dtsc_word_t pk0;
    dtsc_word_t nt;
    logic sample_tick;

    // A short sample period keeps the tone windows brief.
    dtsc_top #(.SAMPLE_DIV(4)) i_dtsc_top (
        .CLK(clk),
        .RESET(reset),
        .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr),
        .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata),
        .DET_STROBE(det_strobe),
        .DET_VALID(det_valid),
        .DET_KEY(det_key),
        .VOICE_IN(voice_in),
        .VOICE_OUT(voice_out),
        .TONE_OUT(tone_out),
        .SAMPLE_TICK(sample_tick)
    );

    dtsc_host_model i_dtsc_host_model (
        .clk(clk),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .wr(reg_wr),
        .rd(reg_rd),
        .rdata(reg_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input dtsc_word_t got, input dtsc_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input string name, input dtsc_addr_t a, input dtsc_word_t exp);
        i_dtsc_host_model.read_reg(a, rv);
        chk(name, rv, exp);
    endtask

    // One detector result, with a voice sample entering in the same cycle.
    task automatic detect(input logic valid, input logic [3:0] key, input dtsc_word_t v);
        @(negedge clk);
        det_strobe = 1'b1;
        det_valid = valid;
        det_key = key;
        voice_in = v;
        @(negedge clk);
        det_strobe = 1'b0;
        chk("voice", voice_out, v);
    endtask

    // Peak magnitude over a hundred samples; an unknown sample spoils the peak.
    task automatic tone_peak(output dtsc_word_t p);
        dtsc_word_t a;
        p = 16'h0000;
        repeat (3) @(negedge clk);
        repeat (400) begin
            @(negedge clk);
            a = tone_out[15] ? -tone_out : tone_out;
            p = (a > p) ? a : p;
        end
    endtask

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        failures++;
        test_done;
    end

    initial begin
        failures = 0;
        cmp_count = 0;
        reset = 1'b1;
        det_strobe = 1'b0;
        det_valid = 1'b0;
        det_key = 4'h0;
        voice_in = 16'h0000;
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        rd_chk("aux reset", `DTSC_ADDR_AUX, 16'h5000);
        rd_chk("irq reset", `DTSC_ADDR_IRQ, 16'h0000);
        rd_chk("txsel read", `DTSC_ADDR_TXSEL, 16'h0000);
        rd_chk("unmapped", 8'h55, 16'h0000);
        // Forty cycles at a divide of four must hold exactly ten sample ticks.
        nt = 16'h0000;
        repeat (40) begin
            @(negedge clk);
            nt = nt + 16'(sample_tick);
        end
        chk("tick rate", nt, 16'h000A);
        $display("Test reset done");
        detect(1'b1, 4'h5, 16'h1234);
        rd_chk("aux mode off", `DTSC_ADDR_AUX, 16'h5000);
        rd_chk("irq mode off", `DTSC_ADDR_IRQ, 16'h0000);
        i_dtsc_host_model.write_reg(`DTSC_ADDR_ANALOG, 16'h001F);
        i_dtsc_host_model.send_digit(1'b0, 2'h0, 1'b0, 4'h1);
        tone_peak(pk);
        chk("tone mode off", pk, 16'h0000);
        $display("Test disabled done");
        i_dtsc_host_model.select_tone_mode(1'b1);
        detect(1'b1, 4'h5, 16'hA5A5);
        rd_chk("aux digit", `DTSC_ADDR_AUX, 16'h4500);
        rd_chk("irq digit", `DTSC_ADDR_IRQ, 16'h0008);
        rd_chk("irq cleared", `DTSC_ADDR_IRQ, 16'h0000);
        detect(1'b1, 4'h3, 16'h8001);
        detect(1'b1, 4'hC, 16'h7FFE);
        rd_chk("aux latest", `DTSC_ADDR_AUX, 16'h4C00);
        rd_chk("irq latest", `DTSC_ADDR_IRQ, 16'h0008);
        detect(1'b0, 4'h7, 16'h0F0F);
        rd_chk("aux null", `DTSC_ADDR_AUX, 16'h5000);
        rd_chk("irq null", `DTSC_ADDR_IRQ, 16'h0000);
        for (int k = 0; k < 16; k++) begin
            detect(1'b1, k[3:0], {12'h000, k[3:0]});
            rd_chk("aux key", `DTSC_ADDR_AUX, {3'b010, 1'b0, k[3:0], 8'h00});
        end
        // A digit landing in the cycle of a status read must survive the clear.
        fork
            detect(1'b1, 4'h9, 16'h0001);
            rd_chk("irq same cycle", `DTSC_ADDR_IRQ, 16'h0008);
        join
        rd_chk("irq set wins", `DTSC_ADDR_IRQ, 16'h0008);
        rd_chk("aux after clear", `DTSC_ADDR_AUX, 16'h4900);
        $display("Test receive done");
        i_dtsc_host_model.send_digit(1'b0, 2'h0, 1'b0, 4'h1);
        tone_peak(pk);
        chk("tone on", {15'h0000, pk != 16'h0000}, 16'h0001);
        tone_peak(pk);
        chk("tone held", {15'h0000, pk != 16'h0000}, 16'h0001);
        for (int k = 0; k < 16; k++) begin
            i_dtsc_host_model.send_digit(1'b0, 2'h0, 1'b1, k[3:0]);
            tone_peak(pk);
            chk("single tone", {15'h0000, pk != 16'h0000}, 16'h0001);
        end
        for (int t = 1; t < 3; t++) begin
            i_dtsc_host_model.send_digit(1'b0, t[1:0], 1'b0, 4'h1);
            tone_peak(pk);
            chk("twist tone", {15'h0000, pk != 16'h0000}, 16'h0001);
        end
        // Digit 1 alone is the low tone, so the deepest twist must shrink it.
        i_dtsc_host_model.send_digit(1'b0, 2'h0, 1'b1, 4'h1);
        tone_peak(pk0);
        i_dtsc_host_model.send_digit(1'b0, 2'h3, 1'b1, 4'h1);
        tone_peak(pk);
        chk("twist depth", {15'h0000, pk < pk0}, 16'h0001);
        i_dtsc_host_model.send_digit(1'b1, 2'h0, 1'b0, 4'h1);
        tone_peak(pk);
        chk("muted", pk, 16'h0000);
        i_dtsc_host_model.write_reg(`DTSC_ADDR_ANALOG, 16'h0000);
        i_dtsc_host_model.send_digit(1'b0, 2'h0, 1'b0, 4'h1);
        tone_peak(pk);
        chk("level zero", pk, 16'h0000);
        i_dtsc_host_model.write_reg(`DTSC_ADDR_ANALOG, 16'h001F);
        tone_peak(pk);
        chk("level full", {15'h0000, pk != 16'h0000}, 16'h0001);
        $display("Test transmit done");
        test_done;
    end
endmodule
